// ===== src/nand_host_ctrl.sv
// NAND flash host controller: pin sequencer driven by a byte request stream
// ============================================================================
// ============================================================================
`timescale 1ns/1ps
`default_nettype none
module nand_host_ctrl #(
  parameter int unsigned BUSY_TIMEOUT = nand_host_pkg::BUSY_TIMEOUT_CYC
) (
  input  wire logic                 CLOCK_I,
  input  wire logic                 RESETN_I,
  // Request stream
  input  wire logic                 REQ_VALID_I,
  output var  logic                 REQ_READY_O,
  input  wire nand_host_pkg::req_s  REQ_I,
  // Read data stream
  output var  logic                 RD_VALID_O,
  input  wire logic                 RD_READY_I,
  output var  logic [7:0]           RD_DATA_O,
  // Status
  output var  logic                 TIMEOUT_O,
  output var  logic                 PROG_LIMIT_O,
  input  wire logic                 WRITE_GUARD_N_I,
  // Flash pins
  output var  logic                 CLE_O,
  output var  logic                 ALE_O,
  output var  logic                 CE_N_O,
  output var  logic                 WRITE_STROBE_N_O,
  output var  logic                 READ_STROBE_N_O,
  output var  logic                 WP_N_O,
  output var  logic [7:0]           IO_O,
  output var  logic                 IO_OE_O,
  input  wire logic [7:0]           IO_I,
  input  wire logic                 READY_BUSY_N_I
);

  // ==========================================================================
  // State
  typedef enum logic [5:0] {
    S_IDLE   = 6'b000001,
    S_WLOW   = 6'b000010,
    S_WHIGH  = 6'b000100,
    S_RLOW   = 6'b001000,
    S_RHIGH  = 6'b010000,
    S_BUSY   = 6'b100000
  } state_e;

  typedef struct packed {
    state_e                      st;
    logic [nand_host_pkg::TIMER_W-1:0] tmr;
    logic                        cle;
    logic                        ale;
    logic                        io_oe;
    logic [7:0]                  io;
    logic [7:0]                  rd_byte;
    logic                        rd_push;
    logic                        timeout;
    logic [2:0]                  prog_cnt;
    logic                        prog_limit;
    logic                        need_reset;
  } ctrl_s;

  ctrl_s s_r;
  ctrl_s s_nxt;
  logic  buf_ready;
  logic  hold_for_reset;

  localparam logic [nand_host_pkg::TIMER_W-1:0] T_WLOW  = nand_host_pkg::TIMER_W'(nand_host_pkg::STROBE_LOW_CYC);
  localparam logic [nand_host_pkg::TIMER_W-1:0] T_WHIGH = nand_host_pkg::TIMER_W'(nand_host_pkg::STROBE_HIGH_CYC);
  localparam logic [nand_host_pkg::TIMER_W-1:0] T_RACC  = nand_host_pkg::TIMER_W'(nand_host_pkg::READ_ACCESS_CYC);
  localparam logic [nand_host_pkg::TIMER_W-1:0] T_TURN  = nand_host_pkg::TIMER_W'(nand_host_pkg::TURNAROUND_CYC);
  localparam logic [nand_host_pkg::TIMER_W-1:0] T_WB    = nand_host_pkg::TIMER_W'(nand_host_pkg::BUSY_START_CYC);
  localparam logic [nand_host_pkg::TIMER_W-1:0] T_BUSY  = nand_host_pkg::TIMER_W'(BUSY_TIMEOUT);
  localparam logic [2:0] PROG_MAX = 3'(nand_host_pkg::MAX_PARTIAL_PROG);

  // After a 15h close only status polls, reads, waits and the reset pass
  assign hold_for_reset = s_r.need_reset &&
                          (REQ_I.op == nand_host_pkg::OP_ADDR || REQ_I.op == nand_host_pkg::OP_WR ||
                           (REQ_I.op == nand_host_pkg::OP_CMD && REQ_I.data != nand_host_pkg::CMD_STATUS &&
                            REQ_I.data != nand_host_pkg::CMD_RESET));

  // Requests taken only in idle; reads also need a free buffer slot
  assign REQ_READY_O = (s_r.st == S_IDLE) && !hold_for_reset &&
                       !(REQ_I.op == nand_host_pkg::OP_RD && !buf_ready);

  // ==========================================================================
  // Sequencer
  always_comb begin
    s_nxt         = s_r;
    s_nxt.rd_push = 1'b0;
    if (s_r.tmr != '0) begin
      s_nxt.tmr = s_r.tmr - 1'b1;
    end
    unique case (s_r.st)
      S_IDLE: begin
        s_nxt.cle   = 1'b0;
        s_nxt.ale   = 1'b0;
        if (REQ_VALID_I && REQ_READY_O) begin
          s_nxt.io = REQ_I.data;
          unique case (REQ_I.op)
            nand_host_pkg::OP_CMD: begin
              s_nxt.cle   = 1'b1;
              s_nxt.io_oe = 1'b1;
              s_nxt.st    = S_WLOW;
              s_nxt.tmr   = T_WLOW;
              if (REQ_I.data == nand_host_pkg::CMD_RESET) begin
                s_nxt.need_reset = 1'b0;
                s_nxt.prog_cnt   = '0;
              end
              if (REQ_I.data == nand_host_pkg::CMD_PROG_FINAL ||
                  REQ_I.data == nand_host_pkg::CMD_CACHE_PROG) begin
                if (s_r.prog_cnt == PROG_MAX) begin
                  s_nxt.prog_limit = 1'b1;
                end else begin
                  s_nxt.prog_cnt = s_r.prog_cnt + 3'h1;
                end
              end
              if (REQ_I.data == nand_host_pkg::CMD_CACHE_PROG) begin
                s_nxt.need_reset = 1'b1;
              end
            end
            nand_host_pkg::OP_ADDR: begin
              s_nxt.ale   = 1'b1;
              s_nxt.io_oe = 1'b1;
              s_nxt.st    = S_WLOW;
              s_nxt.tmr   = T_WLOW;
            end
            nand_host_pkg::OP_WR: begin
              s_nxt.io_oe = 1'b1;
              s_nxt.st    = S_WLOW;
              s_nxt.tmr   = T_WLOW;
            end
            nand_host_pkg::OP_RD: begin
              s_nxt.io_oe = 1'b0;
              s_nxt.st    = S_RLOW;
              s_nxt.tmr   = T_RACC;
            end
            nand_host_pkg::OP_WAIT: begin
              s_nxt.io_oe   = 1'b0;
              s_nxt.st      = S_BUSY;
              s_nxt.tmr     = T_BUSY;
              s_nxt.timeout = 1'b0;
            end
            default: begin
              s_nxt.st = S_IDLE;
            end
          endcase
        end
      end
      S_WLOW: begin
        if (s_r.tmr == '0) begin
          s_nxt.st  = S_WHIGH;
          s_nxt.tmr = (s_r.cle || s_r.ale) ? T_WB : T_WHIGH;
        end
      end
      S_WHIGH: begin
        if (s_r.tmr == '0) begin
          s_nxt.io_oe = 1'b0;
          s_nxt.cle   = 1'b0;
          s_nxt.ale   = 1'b0;
          s_nxt.st    = S_IDLE;
        end
      end
      S_RLOW: begin
        if (s_r.tmr == '0) begin
          s_nxt.rd_byte = IO_I;
          s_nxt.rd_push = 1'b1;
          s_nxt.st      = S_RHIGH;
          s_nxt.tmr     = T_TURN;
        end
      end
      S_RHIGH: begin
        // Long high phase lets outputs turn off before any write drives the bus
        if (s_r.tmr == '0) begin
          s_nxt.st = S_IDLE;
        end
      end
      S_BUSY: begin
        if (READY_BUSY_N_I) begin
          s_nxt.st = S_IDLE;
        end else if (s_r.tmr == '0) begin
          s_nxt.timeout = 1'b1;
          s_nxt.st      = S_IDLE;
        end
      end
      default: begin
        s_nxt.st = S_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      s_r    <= '0;
      s_r.st <= S_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Read data buffer
  nand_skid_buf #(
    .WIDTH(8)
  ) u_rd_buf (
    .clk_i       (CLOCK_I),
    .rst_n_i     (RESETN_I),
    .in_valid_i  (s_r.rd_push),
    .in_ready_o  (buf_ready),
    .in_data_i   (s_r.rd_byte),
    .out_valid_o (RD_VALID_O),
    .out_ready_i (RD_READY_I),
    .out_data_o  (RD_DATA_O)
  );

  // ==========================================================================
  // Pins
  assign CLE_O            = s_r.cle;
  assign ALE_O            = s_r.ale;
  assign CE_N_O           = 1'b0;
  assign WRITE_STROBE_N_O = (s_r.st != S_WLOW);
  assign READ_STROBE_N_O  = (s_r.st != S_RLOW);
  assign WP_N_O           = WRITE_GUARD_N_I;
  assign IO_O             = s_r.io;
  assign IO_OE_O          = s_r.io_oe;
  assign TIMEOUT_O        = s_r.timeout;
  assign PROG_LIMIT_O     = s_r.prog_limit;

endmodule : nand_host_ctrl
`default_nettype wire

// ===== common/nand_host_pkg.sv
// Package of NAND host controller constants, types and timing
package nand_host_pkg;

  // ==========================================================================
  // Clock and timing
  localparam int unsigned CLK_MHZ             = 250;
  localparam int unsigned READ_BUSY_US        = 25;   // array_to_register_duration
  localparam int unsigned PROG_BUSY_US        = 700;  // page_program_duration
  localparam int unsigned ERASE_BUSY_MS       = 10;   // block_erase_duration
  localparam int unsigned CACHE_SHORT_US      = 10;   // write_cache_busy_short
  localparam int unsigned CACHE_LONG_US       = 700;  // write_cache_busy_long
  localparam int unsigned READ_CACHE_US       = 25;   // read_cache_busy
  localparam int unsigned COPY_CACHE_US       = 30;   // copy_cache_busy
  localparam int unsigned RESET_ERASE_US      = 500;
  localparam int unsigned OUT_HOLD_FALL_NS    = 5;    // output_hold_after_fall
  localparam int unsigned STROBE_LOW_NS       = 12;
  localparam int unsigned STROBE_HIGH_NS      = 10;   // read_strobe_high_time
  localparam int unsigned READ_ACCESS_NS      = 20;
  localparam int unsigned TURNAROUND_NS       = 60;
  localparam int unsigned BUSY_START_NS       = 100;
  localparam int unsigned CLK_PS              = 1000000 / CLK_MHZ;
  // Least times round up
  localparam int unsigned STROBE_LOW_CYC  = (STROBE_LOW_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned STROBE_HIGH_CYC = (STROBE_HIGH_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned READ_ACCESS_CYC = (READ_ACCESS_NS * 1000 + CLK_PS - 1) / CLK_PS + 1;
  localparam int unsigned TURNAROUND_CYC  = (TURNAROUND_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned BUSY_START_CYC  = (BUSY_START_NS * 1000 + CLK_PS - 1) / CLK_PS;
  // Longest waits: default timeout for busy (block erase worst is 10 ms)
  localparam int unsigned BUSY_TIMEOUT_CYC = ERASE_BUSY_MS * 1000 * CLK_MHZ;
  localparam int unsigned TIMER_W          = 24;

  // ==========================================================================
  // Command codes and status
  localparam logic [7:0] CMD_STATUS     = 8'h70;
  localparam logic [7:0] CMD_RESET      = 8'hFF;
  localparam logic [7:0] CMD_LOAD       = 8'h80;
  localparam logic [7:0] CMD_PROG_FINAL = 8'h10;
  localparam logic [7:0] CMD_CACHE_PROG = 8'h15;
  localparam int unsigned STATUS_READY_BIT = 6;  // status_ready_bit
  localparam int unsigned MAX_PARTIAL_PROG = 4;

  // ==========================================================================
  // Request kinds
  typedef enum logic [2:0] {
    OP_CMD  = 3'h0,
    OP_ADDR = 3'h1,
    OP_WR   = 3'h2,
    OP_RD   = 3'h3,
    OP_WAIT = 3'h4
  } op_e;

  typedef struct packed {
    op_e        op;
    logic [7:0] data;
  } req_s;

  typedef struct packed {
    logic       cle;
    logic       ale;
    logic       ce_n;
    logic       write_strobe_n;
    logic       read_strobe_n;
    logic       wp_n;
    logic [7:0] io_out;
    logic       io_oe;
  } pins_s;

endpackage : nand_host_pkg

// ===== src/nand_skid_buf.sv
// Two-entry valid/ready buffer for read data
`timescale 1ns/1ps
`default_nettype none
module nand_skid_buf #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output var  logic             in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output var  logic             out_valid_o,
  input  wire logic             out_ready_i,
  output var  logic [WIDTH-1:0] out_data_o
);

  typedef struct packed {
    logic [1:0][WIDTH-1:0] mem;
    logic                  rd;
    logic                  wr;
    logic [1:0]            cnt;
  } state_s;

  state_s st_r;
  state_s st_nxt;
  logic   push;
  logic   pop;

  assign in_ready_o  = (st_r.cnt != 2'h2);
  assign out_valid_o = (st_r.cnt != 2'h0);
  assign out_data_o  = st_r.mem[st_r.rd];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.mem[st_r.wr] = in_data_i;
      st_nxt.wr           = ~st_r.wr;
    end
    if (pop) begin
      st_nxt.rd = ~st_r.rd;
    end
    st_nxt.cnt = st_r.cnt + {1'b0, push} - {1'b0, pop};
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : nand_skid_buf
`default_nettype wire

// ===== tb/nand_host_sva.sv
// Checker of the host controller pins and read stream
`timescale 1ns/1ps
`default_nettype none
module nand_host_sva (
  input wire logic       CLOCK_I,
  input wire logic       RESETN_I,
  input wire logic       REQ_READY_O,
  input wire logic       RD_VALID_O,
  input wire logic       RD_READY_I,
  input wire logic [7:0] RD_DATA_O,
  input wire logic       CLE_O,
  input wire logic       ALE_O,
  input wire logic       WRITE_STROBE_N_O,
  input wire logic       READ_STROBE_N_O,
  input wire logic [7:0] IO_O,
  input wire logic       IO_OE_O,
  input wire logic       READY_BUSY_N_I
);
  // ====
  // Pin timing and stream properties
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  a_bus_no_fight: assert property (!READ_STROBE_N_O |-> !IO_OE_O)
    else $error("host drives bus in read");
  a_select_excl: assert property (!(CLE_O && ALE_O))
    else $error("both latch selects high");
  a_cmd_stands: assert property ($fell(WRITE_STROBE_N_O) |=>
    (IO_OE_O && $stable(IO_O) && $stable(CLE_O) && $stable(ALE_O))[*3]) else $error("byte moved in write");
  a_write_pulse: assert property ($fell(WRITE_STROBE_N_O) |-> (!WRITE_STROBE_N_O)[*3])
    else $error("write pulse short");
  a_read_pulse: assert property ($fell(READ_STROBE_N_O) |-> (!READ_STROBE_N_O && !IO_OE_O)[*3])
    else $error("read pulse short");
  a_read_high: assert property ($rose(READ_STROBE_N_O) |-> READ_STROBE_N_O[*3])
    else $error("read high phase short");
  a_busy_cmd_only: assert property ($fell(WRITE_STROBE_N_O) && CLE_O && !READY_BUSY_N_I
    |-> IO_O inside {8'h70, 8'hFF}) else $error("command while busy");
  a_rd_hold: assert property (RD_VALID_O && !RD_READY_I |=> RD_VALID_O && $stable(RD_DATA_O))
    else $error("read byte lost");
  a_busy_refuse: assert property (!WRITE_STROBE_N_O || !READ_STROBE_N_O |-> !REQ_READY_O)
    else $error("request taken mid cycle");
endmodule : nand_host_sva
bind nand_host_ctrl nand_host_sva nand_host_sva_i (.CLOCK_I(CLOCK_I), .RESETN_I(RESETN_I),
  .REQ_READY_O(REQ_READY_O), .RD_VALID_O(RD_VALID_O), .RD_READY_I(RD_READY_I), .RD_DATA_O(RD_DATA_O),
  .CLE_O(CLE_O), .ALE_O(ALE_O), .WRITE_STROBE_N_O(WRITE_STROBE_N_O), .READ_STROBE_N_O(READ_STROBE_N_O),
  .IO_O(IO_O), .IO_OE_O(IO_OE_O), .READY_BUSY_N_I(READY_BUSY_N_I));
`default_nettype wire

// ===== tb/nand_flash_model.sv
// Behavioural flash device answering the host controller
`timescale 1ns/1ps
`default_nettype none
module nand_flash_model #(
  parameter int R_CYC   = 40,
  parameter int P_CYC   = 120,
  parameter int E_CYC   = 180,
  parameter int C_CYC   = 20,
  parameter int RST_CYC = 15
) (
  input  wire logic       clk_i,
  input  wire logic       cle_i,
  input  wire logic       ale_i,
  input  wire logic       write_strobe_n_i,
  input  wire logic       read_strobe_n_i,
  input  wire logic [7:0] io_i,
  input  wire logic       stuck_i,
  output var  logic [7:0] io_o,
  output var  logic       io_oe_o,
  output var  logic       ready_busy_n_o
);
  // ====
  // Page, column counter and busy timer
  logic [7:0] page [256];
  logic [7:0] col_r = 8'h00;
  logic       ws_r = 1'b1;
  logic       rs_r = 1'b1;
  logic       stat_r = 1'b0;
  int         busy_r = 0;
  int         hold_r = 0;
  // Busy times shortened, order kept: copy > read > short cache
  function automatic int busy_len(input logic [7:0] c);
    case (c)
      8'h30, 8'h31, 8'h3F: return R_CYC;
      8'h10, 8'h15: return P_CYC;
      8'hD0: return E_CYC;
      8'h11: return C_CYC;
      8'h3A: return R_CYC + 10;
      8'hFF: return RST_CYC;
      default: return 0;
    endcase
  endfunction : busy_len
  assign ready_busy_n_o = (busy_r == 0) && !stuck_i;
  initial begin
    io_o = 8'h00;
    io_oe_o = 1'b0;
  end
  always @(posedge clk_i) begin
    ws_r <= write_strobe_n_i;
    rs_r <= read_strobe_n_i;
    if (busy_r > 0) busy_r <= busy_r - 1;
    if (!ws_r && write_strobe_n_i) begin
      if (cle_i) begin
        stat_r <= (io_i == 8'h70);
        if (busy_len(io_i) > 0) busy_r <= busy_len(io_i);
      end else if (ale_i) begin
        col_r <= io_i;
      end else begin
        page[col_r] <= io_i;
        col_r <= col_r + 8'h01;
      end
    end
    if (rs_r && !read_strobe_n_i) begin
      io_oe_o <= 1'b1;
      hold_r <= 0;
      io_o <= stat_r ? {1'b0, ready_busy_n_o, 6'h00} : page[col_r];
      if (!stat_r) col_r <= col_r + 8'h01;
    end else if (io_oe_o && read_strobe_n_i) begin
      hold_r <= hold_r + 1;
      // Data held 28 ns past the strobe rise, then the bus floats
      if (hold_r == 6 || cle_i || ale_i || !write_strobe_n_i) io_oe_o <= 1'b0;
    end else if (!io_oe_o) begin
      io_o <= ~io_o;
    end
  end
endmodule : nand_flash_model
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench of the host controller against the flash model
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin err_count++; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module testbench;
  logic clk = 0, rst_n = 0, req_valid = 0, rd_ready = 0, guard_n = 1, stuck = 0, stall = 0;
  logic rq_rdy, rd_valid, tmo, plim, cle, ale, ws_n, rs_n, io_oe, dev_oe, rb_n, ce_n, wp_n;
  logic [7:0] rd_data, io_o, dev_io, io_bus, col;
  logic [7:0] page_m [256];
  logic [7:0] exp_q [$];
  logic [7:0] codes [6] = '{8'h11, 8'h31, 8'h3F, 8'h3A, 8'hD0, 8'hFF};
  nand_host_pkg::req_s req = '0;
  int err_count = 0, num_checks = 0, cyc = 0;
  always #2 clk = ~clk;
  assign io_bus = io_oe ? io_o : dev_io;
  nand_host_ctrl #(.BUSY_TIMEOUT(200)) nand_host_ctrl_i (.CLOCK_I(clk), .RESETN_I(rst_n),
    .REQ_VALID_I(req_valid), .REQ_READY_O(rq_rdy), .REQ_I(req), .RD_VALID_O(rd_valid),
    .RD_READY_I(rd_ready), .RD_DATA_O(rd_data), .TIMEOUT_O(tmo), .PROG_LIMIT_O(plim),
    .WRITE_GUARD_N_I(guard_n), .CLE_O(cle), .ALE_O(ale), .CE_N_O(ce_n), .WRITE_STROBE_N_O(ws_n),
    .READ_STROBE_N_O(rs_n), .WP_N_O(wp_n), .IO_O(io_o), .IO_OE_O(io_oe), .IO_I(io_bus), .READY_BUSY_N_I(rb_n));
  nand_flash_model nand_flash_model_i (.clk_i(clk), .cle_i(cle), .ale_i(ale), .write_strobe_n_i(ws_n),
    .read_strobe_n_i(rs_n), .io_i(io_bus), .stuck_i(stuck), .io_o(dev_io), .io_oe_o(dev_oe), .ready_busy_n_o(rb_n));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : stop_test
  task automatic send(input nand_host_pkg::op_e op, input logic [7:0] d);
    @(negedge clk);
    req_valid = 1;
    req.op = op;
    req.data = d;
    // Ready decodes the op, so let it settle before looking
    #1;
    while (rq_rdy !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 0;
  endtask : send
  task automatic cmd_wait(input logic [7:0] c);
    send(nand_host_pkg::OP_CMD, c);
    send(nand_host_pkg::OP_WAIT, 8'h00);
    do @(negedge clk); while (rq_rdy !== 1'b1);
  endtask : cmd_wait
  // ====
  // Read stream scoreboard, bus watch and hang limit
  always @(negedge clk) begin
    rd_ready = !stall && ($urandom_range(0, 3) != 0);
    `CHK({ce_n, wp_n}, {1'b0, guard_n})
    guard_n = ($urandom_range(0, 7) != 0);
    if (dev_oe && io_oe) `CHK(io_oe, 1'b0)
    if (rd_valid === 1'b1 && rd_ready) begin
      if (exp_q.size() == 0) `CHK(rd_valid, 1'b0)
      else `CHK(rd_data, exp_q.pop_front())
    end
    cyc++;
    if (cyc > 60000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'h00C8));
    repeat (5) @(negedge clk);
    `CHK({cle, ale, ws_n, rs_n, io_oe, rq_rdy}, 6'h0D)
    rst_n = 1;
    col = 8'($urandom_range(0, 250));
    send(nand_host_pkg::OP_CMD, 8'h80);
    send(nand_host_pkg::OP_ADDR, col);
    for (int i = 0; i < 4; i++) begin
      page_m[col + i] = 8'($urandom);
      send(nand_host_pkg::OP_WR, page_m[col + i]);
    end
    cmd_wait(8'h10);
    `CHK({tmo, rb_n}, 2'b01)
    $display("test program done");
    send(nand_host_pkg::OP_CMD, 8'h00);
    send(nand_host_pkg::OP_ADDR, col);
    cmd_wait(8'h30);
    stall = 1;
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(page_m[col + i]);
      if (i == 2) begin
        repeat (60) @(negedge clk);
        req.op = nand_host_pkg::OP_RD;
        req_valid = 1;
        repeat (40) @(negedge clk);
        `CHK(rq_rdy, 1'b0)
        stall = 0;
      end
      send(nand_host_pkg::OP_RD, 8'h00);
    end
    $display("test read and stall done");
    send(nand_host_pkg::OP_CMD, 8'h80);
    send(nand_host_pkg::OP_ADDR, col);
    send(nand_host_pkg::OP_WR, page_m[col]);
    send(nand_host_pkg::OP_CMD, 8'h15);
    exp_q.push_back(8'h00);
    exp_q.push_back(8'h40);
    send(nand_host_pkg::OP_CMD, 8'h70);
    send(nand_host_pkg::OP_RD, 8'h00);
    cmd_wait(8'h70);
    send(nand_host_pkg::OP_RD, 8'h00);
    do @(negedge clk); while (rq_rdy !== 1'b1);
    req.op = nand_host_pkg::OP_CMD;
    req.data = 8'h80;
    #1;
    `CHK(rq_rdy, 1'b0)
    cmd_wait(8'hFF);
    $display("test cache close done");
    foreach (codes[k]) begin
      cmd_wait(codes[k]);
      `CHK(tmo, 1'b0)
    end
    stuck = 1;
    send(nand_host_pkg::OP_WAIT, 8'h00);
    do @(negedge clk); while (rq_rdy !== 1'b1);
    `CHK(tmo, 1'b1)
    stuck = 0;
    cmd_wait(8'hFF);
    `CHK(tmo, 1'b0)
    $display("test busy codes and timeout done");
    for (int i = 0; i < 5; i++) begin
      send(nand_host_pkg::OP_CMD, 8'h80);
      cmd_wait(8'h10);
      `CHK(plim, i == 4)
    end
    $display("test program limit done");
    while (exp_q.size() != 0) @(negedge clk);
    stop_test();
  end
endmodule : testbench
`default_nettype wire
